// ### logic/fpmb_device.sv
// program memory front end: banking, flash control, access gating, debug
//
// Behaviour
// R1: flash and registers seen in 64 KB space
// R2: flash control registers at 0x0401, 0x0402
// R3: software keeps user code out of 0400h-05FFh
// R4: second register writes need top bit one
// R5: software sets clock range before erase/program
// R6: software keeps low six bits at zero
// R7: common area maps straight, any bank
// R8: selected bank fills window 8000h-FFFFh
// R9: bank field selects bank, resets to one
// R10: 512-byte pages, read, program, erase, mass erase
// R11: low mode pin gives debug, port0 as JTAG
// R12: debug blocks sleep and masks resets; the code masks POR, BOR and watchdog only, the external reset pin still resets
// R13: debug entry while asleep restores power
// R14: test clock slow at entry, commands switch
// R15: protection bit taken from flash 0x0400
// R16: unprotected debug: only upper reads, mass erase
// R17: protected debug: everything allowed
// R18: normal mode: low area read-only, no mass erase
// R19: protection latched only at hard reset
// R20: resets and wakeups restore control registers
// R21: bank change only affects later accesses
//
// Local design decision: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "fpmb_params.svh"
module fpmb_device (
	fpmb_link_if.dev         lnk,
	output logic             fl_req,
	output fpmb_pkg::fpmb_op_t fl_op,
	output logic [16:0]      fl_addr,
	output logic [7:0]       fl_wdata,
	input  wire logic [7:0]  fl_rdata,
	input  wire logic        fl_done,
	output logic [7:0]       fl_ctrl0,
	output logic             fl_clk_range,
	input  wire logic [3:0]  gpio_out,
	input  wire logic [3:0]  gpio_oe,
	output logic [3:0]       gpio_in,
	output logic             jtag_tck,
	output logic             jtag_tms,
	output logic             jtag_tdi,
	input  wire logic        jtag_tdo,
	output logic             debug_mode
);
	// ----------------------------------------
	// decode functions
	// ----------------------------------------
	function automatic logic [16:0] map_addr(input logic [15:0] a,
		input logic [1:0] bank);
		map_addr = a[`FPMB_WIN_BIT] ? {bank, a[14:0]} : {2'b00, a[14:0]}; // R7 R8
	endfunction

	function automatic logic allowed(input fpmb_pkg::fpmb_op_t op,
		input logic [16:0] fa, input logic dbg, input logic prot);
		if (dbg) begin
			if (prot)
				allowed = 1'b1; // R17
			else if (op == fpmb_pkg::fpmb_op_mass_erase)
				allowed = 1'b1; // R16
			else
				allowed = (op == fpmb_pkg::fpmb_op_read) &&
					(fa >= `FPMB_DBG_READ_BASE); // R16
		end else begin
			if (op == fpmb_pkg::fpmb_op_mass_erase)
				allowed = 1'b0; // R18
			else if (fa <= `FPMB_IAP_LOW_TOP)
				allowed = (op == fpmb_pkg::fpmb_op_read); // R18
			else
				allowed = 1'b1; // R18
		end
	endfunction

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [5:0] sync1_q;
	logic [5:0] sync2_q;
	always_ff @(posedge lnk.ref_clk) begin
		if (!lnk.rst_n) begin
			sync1_q <= 6'h30;
			sync2_q <= 6'h30;
		end else begin
			sync1_q <= {lnk.external_reset_pin_n, lnk.debug_mode_pin_n,
				lnk.p0_in};
			sync2_q <= sync1_q;
		end
	end
	logic       pin_rst;
	logic       pin_dbg;
	logic [3:0] pin_p0;
	assign pin_rst = !sync2_q[5];
	assign pin_dbg = !sync2_q[4];
	assign pin_p0  = sync2_q[3:0];

	// ----------------------------------------
	// main state
	// ----------------------------------------
	fpmb_pkg::fpmb_dev_state_t state_q, state_d;
	fpmb_pkg::fpmb_op_t op_q, op_d;
	logic [1:0]  bank_q, bank_d;
	logic [7:0]  ctrl0_q, ctrl0_d;
	logic [6:0]  ctrl1_q, ctrl1_d;
	logic        prot_q, prot_d;
	logic        dbg_q, dbg_d;
	logic        fast_q, fast_d;
	logic [1:0]  sleep_q, sleep_d;
	logic        restore_q, restore_d;
	logic        core_rst_q, core_rst_d;
	logic        ack_q, ack_d;
	logic        err_q, err_d;
	logic [7:0]  rdata_q, rdata_d;
	logic        freq_q, freq_d;
	logic [16:0] faddr_q, faddr_d;
	logic [7:0]  fwdata_q, fwdata_d;
	logic [3:0]  p0_out_q, p0_out_d;
	logic [3:0]  p0_oe_q, p0_oe_d;
	logic [3:0]  gin_q, gin_d;
	logic [2:0]  jtag_q, jtag_d;
	logic [16:0] req_fa;
	logic        lvl1;
	logic        lvl2;
	logic        is_wr;

	always_comb begin
		state_d    = state_q;
		op_d       = op_q;
		bank_d     = bank_q;
		ctrl0_d    = ctrl0_q;
		ctrl1_d    = ctrl1_q;
		prot_d     = prot_q;
		fast_d     = fast_q;
		sleep_d    = sleep_q;
		restore_d  = 1'b0;
		core_rst_d = 1'b0;
		ack_d      = 1'b0;
		err_d      = err_q;
		rdata_d    = rdata_q;
		freq_d     = 1'b0;
		faddr_d    = faddr_q;
		fwdata_d   = fwdata_q;
		dbg_d      = pin_dbg; // R11
		req_fa     = map_addr(lnk.addr, bank_q);
		is_wr      = (lnk.op == fpmb_pkg::fpmb_op_write);
		// port0 becomes the JTAG group in debug, tdo is the one output
		p0_oe_d    = pin_dbg ? 4'h8 : gpio_oe; // R11
		p0_out_d   = pin_dbg ? {jtag_tdo, 3'h0} : gpio_out; // R11
		gin_d      = pin_p0;
		jtag_d     = pin_dbg ? pin_p0[2:0] : 3'h0; // R11
		if (pin_dbg && !dbg_q) begin
			fast_d = 1'b0; // R14
			if (sleep_q != 2'h0)
				restore_d = 1'b1; // R13
		end
		if (pin_dbg && lnk.jtag_cmd_valid) begin
			if (lnk.jtag_cmd == `FPMB_JTAG_FAST_CMD)
				fast_d = 1'b1; // R14
			else if (lnk.jtag_cmd == `FPMB_JTAG_SLOW_CMD)
				fast_d = 1'b0; // R14
		end
		if (!pin_dbg && sleep_q == 2'h0 && lnk.sleep_req != 2'h0)
			sleep_d = lnk.sleep_req[0] ? 2'h1 : 2'h2; // R12
		case (state_q)
			fpmb_pkg::fpmb_st_prot: begin
				freq_d  = 1'b1; // R15
				op_d    = fpmb_pkg::fpmb_op_read;
				faddr_d = `FPMB_PROT_ADDR;
				state_d = fpmb_pkg::fpmb_st_prot_wait;
			end
			fpmb_pkg::fpmb_st_prot_wait: begin
				if (fl_done) begin
					prot_d  = fl_rdata[`FPMB_PROT_BIT]; // R15 R19
					state_d = fpmb_pkg::fpmb_st_idle;
				end
			end
			fpmb_pkg::fpmb_st_idle: begin
				if (lnk.req) begin
					ack_d   = 1'b1;
					err_d   = 1'b0;
					state_d = fpmb_pkg::fpmb_st_drop;
					if (lnk.space) begin
						if (lnk.addr[7:0] != `FPMB_BANK_SFR || lnk.op[1])
							err_d = 1'b1;
						else if (is_wr) begin
							// a zero bank code is reserved and leaves the window alone
							if (lnk.wdata[1:0] != 2'h0)
								bank_d = lnk.wdata[1:0]; // R9 R21
						end else
							rdata_d = {6'h00, bank_q}; // R9
					end else if (!lnk.op[1] &&
						lnk.addr == `FPMB_CTRL0_ADDR) begin
						if (is_wr)
							ctrl0_d = lnk.wdata; // R2
						else
							rdata_d = ctrl0_q; // R2
					end else if (!lnk.op[1] &&
						lnk.addr == `FPMB_CTRL1_ADDR) begin
						if (is_wr) begin
							if (lnk.wdata[`FPMB_CTRL1_UNLOCK])
								ctrl1_d = lnk.wdata[6:0]; // R4
						end else
							rdata_d = {1'b0, ctrl1_q}; // R2
					end else if (allowed(lnk.op, req_fa, dbg_q, prot_q)) begin
						ack_d    = 1'b0;
						freq_d   = 1'b1; // R1 R10
						op_d     = lnk.op;
						faddr_d  = req_fa;
						fwdata_d = lnk.wdata;
						state_d  = fpmb_pkg::fpmb_st_flash;
					end else
						err_d = 1'b1; // R16 R18
				end
			end
			fpmb_pkg::fpmb_st_flash: begin
				if (fl_done) begin
					ack_d   = 1'b1;
					rdata_d = fl_rdata;
					state_d = fpmb_pkg::fpmb_st_drop;
				end
			end
			fpmb_pkg::fpmb_st_drop: begin
				// hold until the requester drops req so one order runs once
				if (!lnk.req)
					state_d = fpmb_pkg::fpmb_st_idle;
			end
			default: state_d = fpmb_pkg::fpmb_st_prot;
		endcase
		lvl2 = lnk.wake_evt || restore_d;
		lvl1 = pin_rst ||
			(!dbg_q && (lnk.por_evt || lnk.bor_evt || lnk.wdt_evt)); // R12
		if (lvl1 || lvl2) begin
			ctrl0_d    = `FPMB_CTRL0_RST; // R20
			ctrl1_d    = `FPMB_CTRL1_RST; // R20
			sleep_d    = 2'h0;
			core_rst_d = 1'b1;
		end
		if (lvl1) begin
			bank_d  = `FPMB_BANK_RST;
			fast_d  = 1'b0;
			ack_d   = 1'b0;
			freq_d  = 1'b0;
			state_d = fpmb_pkg::fpmb_st_prot; // R19
		end
	end

	always_ff @(posedge lnk.ref_clk) begin
		if (!lnk.rst_n) begin
			state_q    <= fpmb_pkg::fpmb_st_prot;
			op_q       <= fpmb_pkg::fpmb_op_read;
			bank_q     <= `FPMB_BANK_RST; // R9
			ctrl0_q    <= `FPMB_CTRL0_RST;
			ctrl1_q    <= `FPMB_CTRL1_RST; // R5
			prot_q     <= 1'b0;
			dbg_q      <= 1'b0;
			fast_q     <= 1'b0;
			sleep_q    <= 2'h0;
			restore_q  <= 1'b0;
			core_rst_q <= 1'b1;
			ack_q      <= 1'b0;
			err_q      <= 1'b0;
			rdata_q    <= 8'h00;
			freq_q     <= 1'b0;
			faddr_q    <= 17'h00000;
			fwdata_q   <= 8'h00;
			p0_out_q   <= 4'h0;
			p0_oe_q    <= 4'h0;
			gin_q      <= 4'h0;
			jtag_q     <= 3'h0;
		end else begin
			state_q    <= state_d;
			op_q       <= op_d;
			bank_q     <= bank_d;
			ctrl0_q    <= ctrl0_d;
			ctrl1_q    <= ctrl1_d;
			prot_q     <= prot_d;
			dbg_q      <= dbg_d;
			fast_q     <= fast_d;
			sleep_q    <= sleep_d;
			restore_q  <= restore_d;
			core_rst_q <= core_rst_d;
			ack_q      <= ack_d;
			err_q      <= err_d;
			rdata_q    <= rdata_d;
			freq_q     <= freq_d;
			faddr_q    <= faddr_d;
			fwdata_q   <= fwdata_d;
			p0_out_q   <= p0_out_d;
			p0_oe_q    <= p0_oe_d;
			gin_q      <= gin_d;
			jtag_q     <= jtag_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign lnk.ack           = ack_q;
	assign lnk.err           = err_q;
	assign lnk.rdata         = rdata_q;
	assign lnk.sleep_state   = sleep_q;
	assign lnk.power_restore = restore_q;
	assign lnk.core_reset    = core_rst_q;
	assign lnk.jtag_en       = dbg_q;
	assign lnk.tck_fast      = fast_q;
	assign lnk.p0_out        = p0_out_q;
	assign lnk.p0_oe         = p0_oe_q;
	assign fl_req            = freq_q;
	assign fl_op             = op_q;
	assign fl_addr           = faddr_q;
	assign fl_wdata          = fwdata_q;
	assign fl_ctrl0          = ctrl0_q;
	assign fl_clk_range      = ctrl1_q[`FPMB_CKSEL_BIT]; // R5
	assign gpio_in           = gin_q;
	assign jtag_tck          = jtag_q[0];
	assign jtag_tms          = jtag_q[1];
	assign jtag_tdi          = jtag_q[2];
	assign debug_mode        = dbg_q;
endmodule
`default_nettype wire

// ### logic/fpmb_host.sv
// core and probe end: apb registers drive orders onto the link
`timescale 1ns/10ps
`default_nettype none
`include "fpmb_params.svh"
module fpmb_host (
	fpmb_link_if.host        lnk,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	logic        pready_q, pready_d;
	logic        pslverr_q, pslverr_d;
	logic [31:0] prdata_q, prdata_d;
	logic [26:0] cmd_q, cmd_d;
	logic        req_q, req_d;
	logic        err_q, err_d;
	logic [7:0]  rdat_q, rdat_d;
	logic [6:0]  pins_q, pins_d;
	logic [3:0]  evt_q, evt_d;
	logic        jv_q, jv_d;
	logic [7:0]  jcmd_q, jcmd_d;
	logic [7:0]  tcnt_q, tcnt_d;
	logic        tck_q, tck_d;
	logic        acc;
	logic        wr;
	logic [7:0]  half;

	always_comb begin
		pready_d  = 1'b0;
		pslverr_d = 1'b0;
		prdata_d  = prdata_q;
		cmd_d     = cmd_q;
		req_d     = req_q;
		err_d     = err_q;
		rdat_d    = rdat_q;
		pins_d    = pins_q;
		evt_d     = 4'h0;
		jv_d      = 1'b0;
		jcmd_d    = jcmd_q;
		tck_d     = tck_q;
		tcnt_d    = tcnt_q;
		acc       = psel && penable;
		wr        = acc && pready_q && pwrite;
		// one wait state so the read data can come from a flop
		if (acc && !pready_q) begin
			pready_d = 1'b1;
			case (paddr)
				`FPMB_APB_CMD:    prdata_d = {5'h00, cmd_q};
				`FPMB_APB_STATUS: prdata_d = {10'h000, lnk.p0_out[3],
					lnk.core_reset, lnk.jtag_en, lnk.sleep_state,
					lnk.tck_fast, rdat_q, 6'h00, err_q, req_q};
				`FPMB_APB_PINS:   prdata_d = {25'h0000000, pins_q};
				`FPMB_APB_EVENT:  prdata_d = 32'h0000_0000;
				default: begin
					prdata_d  = 32'h0000_0000;
					pslverr_d = 1'b1;
				end
			endcase
		end
		if (wr && paddr == `FPMB_APB_CMD && !req_q) begin
			cmd_d = pwdata[26:0];
			req_d = pwdata[31];
		end
		if (wr && paddr == `FPMB_APB_PINS)
			pins_d = pwdata[6:0];
		if (wr && paddr == `FPMB_APB_EVENT) begin
			evt_d = pwdata[3:0];
			// commands only make sense once the debug port is live
			jv_d   = pwdata[4] && lnk.jtag_en; // R14
			jcmd_d = pwdata[15:8];
		end
		if (req_q && lnk.ack) begin
			req_d  = 1'b0;
			err_d  = lnk.err;
			rdat_d = lnk.rdata;
		end
		half = lnk.tck_fast ? 8'(`FPMB_TCK_FAST_HALF) :
			8'(`FPMB_TCK_SLOW_HALF); // R14
		if (pins_q[4] && lnk.jtag_en) begin
			if (tcnt_q + 8'h01 >= half) begin
				tcnt_d = 8'h00;
				tck_d  = !tck_q; // R14
			end else
				tcnt_d = tcnt_q + 8'h01;
		end else begin
			tcnt_d = 8'h00;
			tck_d  = 1'b0;
		end
	end

	always_ff @(posedge lnk.ref_clk) begin
		if (!lnk.rst_n) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			cmd_q     <= 27'h0000000;
			req_q     <= 1'b0;
			err_q     <= 1'b0;
			rdat_q    <= 8'h00;
			pins_q    <= 7'(`FPMB_PINS_RST);
			evt_q     <= 4'h0;
			jv_q      <= 1'b0;
			jcmd_q    <= 8'h00;
			tcnt_q    <= 8'h00;
			tck_q     <= 1'b0;
		end else begin
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q  <= prdata_d;
			cmd_q     <= cmd_d;
			req_q     <= req_d;
			err_q     <= err_d;
			rdat_q    <= rdat_d;
			pins_q    <= pins_d;
			evt_q     <= evt_d;
			jv_q      <= jv_d;
			jcmd_q    <= jcmd_d;
			tcnt_q    <= tcnt_d;
			tck_q     <= tck_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign prdata                   = prdata_q;
	assign pready                   = pready_q;
	assign pslverr                  = pslverr_q;
	assign lnk.req                  = req_q;
	assign lnk.wdata                = cmd_q[7:0];
	assign lnk.addr                 = cmd_q[23:8];
	assign lnk.op                   = fpmb_pkg::fpmb_op_t'(cmd_q[25:24]);
	assign lnk.space                = cmd_q[26];
	assign lnk.debug_mode_pin_n     = pins_q[0];
	assign lnk.external_reset_pin_n = pins_q[1];
	assign lnk.sleep_req            = pins_q[3:2];
	assign lnk.por_evt              = evt_q[0];
	assign lnk.bor_evt              = evt_q[1];
	assign lnk.wdt_evt              = evt_q[2];
	assign lnk.wake_evt             = evt_q[3];
	assign lnk.jtag_cmd_valid       = jv_q;
	assign lnk.jtag_cmd             = jcmd_q;
	assign lnk.p0_in                = {1'b0, pins_q[6], pins_q[5], tck_q};
endmodule
`default_nettype wire

// ### logic/fpmb_link_if.sv
// link between the memory front end and the core or debug probe
`timescale 1ns/10ps
`default_nettype none
interface fpmb_link_if (
	input wire logic ref_clk,
	input wire logic rst_n
);
	logic                 req;
	logic                 space;
	fpmb_pkg::fpmb_op_t   op;
	logic [15:0]          addr;
	logic [7:0]           wdata;
	logic                 ack;
	logic                 err;
	logic [7:0]           rdata;
	logic                 debug_mode_pin_n;
	logic                 external_reset_pin_n;
	logic [1:0]           sleep_req;
	logic [1:0]           sleep_state;
	logic                 por_evt;
	logic                 bor_evt;
	logic                 wdt_evt;
	logic                 wake_evt;
	logic                 power_restore;
	logic                 core_reset;
	logic                 jtag_cmd_valid;
	logic [7:0]           jtag_cmd;
	logic                 jtag_en;
	logic                 tck_fast;
	logic [3:0]           p0_in;
	logic [3:0]           p0_out;
	logic [3:0]           p0_oe;
	modport dev (
		input  ref_clk, rst_n, req, space, op, addr, wdata,
		input  debug_mode_pin_n, external_reset_pin_n, sleep_req,
		input  por_evt, bor_evt, wdt_evt, wake_evt,
		input  jtag_cmd_valid, jtag_cmd, p0_in,
		output ack, err, rdata, sleep_state, power_restore,
		output core_reset, jtag_en, tck_fast, p0_out, p0_oe
	);
	modport host (
		input  ref_clk, rst_n, ack, err, rdata, sleep_state,
		input  power_restore, core_reset, jtag_en, tck_fast,
		input  p0_out, p0_oe,
		output req, space, op, addr, wdata,
		output debug_mode_pin_n, external_reset_pin_n, sleep_req,
		output por_evt, bor_evt, wdt_evt, wake_evt,
		output jtag_cmd_valid, jtag_cmd, p0_in
	);
endinterface
`default_nettype wire

// ### logic/fpmb_params.svh
// constants of the flash program memory banking link
`ifndef FPMB_PARAMS_SVH
`define FPMB_PARAMS_SVH
// ----------------------------------------
// program space map
// ----------------------------------------
`define FPMB_CTRL0_ADDR      16'h0401
`define FPMB_CTRL1_ADDR      16'h0402
`define FPMB_PROT_ADDR       17'h00400
`define FPMB_PROT_BIT        0
`define FPMB_WIN_BIT         15
`define FPMB_IAP_LOW_TOP     17'h003ff
`define FPMB_DBG_READ_BASE   17'h18000
// ----------------------------------------
// registers and reset values
// ----------------------------------------
`define FPMB_BANK_SFR        8'ha0
`define FPMB_BANK_RST        2'h1
`define FPMB_CTRL0_RST       8'h00
`define FPMB_CTRL1_RST       7'h00
`define FPMB_CTRL1_UNLOCK    7
`define FPMB_CKSEL_BIT       6
// ----------------------------------------
// debug port
// ----------------------------------------
`define FPMB_JTAG_FAST_CMD   8'h22
`define FPMB_JTAG_SLOW_CMD   8'h23
`define FPMB_CLK_HZ          100000000
`define FPMB_TCK_SLOW_BPS    400000
`define FPMB_TCK_SLOW_HALF   ((`FPMB_CLK_HZ + 2*`FPMB_TCK_SLOW_BPS - 1) / (2*`FPMB_TCK_SLOW_BPS))
`define FPMB_TCK_FAST_HALF   1
// ----------------------------------------
// host apb map
// ----------------------------------------
`define FPMB_APB_CMD         12'h000
`define FPMB_APB_STATUS      12'h004
`define FPMB_APB_PINS        12'h008
`define FPMB_APB_EVENT       12'h00c
`define FPMB_PINS_RST        32'h0000_0003
`endif

// ### logic/fpmb_pkg.sv
// types of the flash program memory banking link
package fpmb_pkg;
	typedef enum logic [1:0] {
		fpmb_op_read       = 2'b00,
		fpmb_op_write      = 2'b01,
		fpmb_op_page_erase = 2'b10,
		fpmb_op_mass_erase = 2'b11
	} fpmb_op_t;
	typedef enum logic [2:0] {
		fpmb_st_prot      = 3'b000,
		fpmb_st_prot_wait = 3'b001,
		fpmb_st_idle      = 3'b010,
		fpmb_st_flash     = 3'b011,
		fpmb_st_drop      = 3'b100
	} fpmb_dev_state_t;
endpackage

// ### verification/fpmb_properties.sv
// concurrent checks on the link between front end and core side
`timescale 1ns/10ps
`default_nettype none
module fpmb_properties (
	input wire logic               ref_clk,
	input wire logic               rst_n,
	input wire logic               space,
	input wire fpmb_pkg::fpmb_op_t op,
	input wire logic [15:0]        addr,
	input wire logic               ack,
	input wire logic               err,
	input wire logic               debug_mode_pin_n,
	input wire logic [1:0]         sleep_state,
	input wire logic               jtag_en,
	input wire logic               tck_fast,
	input wire logic               jtag_cmd_valid,
	input wire logic [7:0]         jtag_cmd,
	input wire logic               power_restore
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// ----------------------------------------
	// answers
	// ----------------------------------------
	property p_sfr_err;
		ack && space && addr != 16'h00a0 |-> err;
	endproperty
	a_sfr_err: assert property (p_sfr_err)
		else $error("unmapped sfr not refused");
	property p_low_wr;
		ack && !space && !jtag_en && op == fpmb_pkg::fpmb_op_write
			&& addr < 16'h0400 |-> err;
	endproperty
	a_low_wr: assert property (p_low_wr)
		else $error("low area write not refused");
	property p_mass_norm;
		ack && !space && !jtag_en && op == fpmb_pkg::fpmb_op_mass_erase |-> err;
	endproperty
	a_mass_norm: assert property (p_mass_norm)
		else $error("mass erase allowed in normal mode");
	property p_mass_dbg;
		ack && !space && jtag_en && op == fpmb_pkg::fpmb_op_mass_erase |-> !err;
	endproperty
	a_mass_dbg: assert property (p_mass_dbg)
		else $error("mass erase refused in debug");
	// ----------------------------------------
	// debug port
	// ----------------------------------------
	// exit edge is excused: sleep may start once debug is gone
	property p_no_sleep;
		jtag_en && $past(jtag_en) && sleep_state == 2'h0
			|=> sleep_state == 2'h0 || !jtag_en;
	endproperty
	a_no_sleep: assert property (p_no_sleep)
		else $error("sleep entered in debug");
	property p_fast;
		jtag_en && jtag_cmd_valid && jtag_cmd == 8'h22 |-> ##[1:4] tck_fast;
	endproperty
	a_fast: assert property (p_fast)
		else $error("fast command ignored");
	property p_slow;
		jtag_en && jtag_cmd_valid && jtag_cmd == 8'h23 |-> ##[1:4] !tck_fast;
	endproperty
	a_slow: assert property (p_slow)
		else $error("slow command ignored");
	property p_entry;
		$rose(jtag_en) |-> !tck_fast;
	endproperty
	a_entry: assert property (p_entry)
		else $error("debug entered with fast clock");
	property p_restore;
		$fell(debug_mode_pin_n) && sleep_state != 2'h0 |-> ##[1:8] power_restore;
	endproperty
	a_restore: assert property (p_restore)
		else $error("no power restore on debug entry");
endmodule
`default_nettype wire

// ### verification/fpmb_tb_top.sv
// bench: apb orders cross the link to the memory front end
`timescale 1ns/10ps
`default_nettype none
module fpmb_tb_top;
	logic               ref_clk;
	logic               rst_n;
	logic               psel;
	logic               penable;
	logic               pwrite;
	logic [11:0]        paddr;
	logic [31:0]        pwdata;
	logic [31:0]        prdata;
	logic               pready;
	logic               pslverr;
	logic               fl_req;
	fpmb_pkg::fpmb_op_t fl_op;
	fpmb_pkg::fpmb_op_t last_op;
	logic [16:0]        fl_addr;
	logic [16:0]        last_fa;
	logic [7:0]         fl_rdata = 8'h00;
	logic [7:0]         fl_ctrl0;
	logic [7:0]         rd;
	logic [7:0]         fl_wd;
	logic               tms;
	logic               fl_done = 1'h0;
	logic [1:0]         fl_cnt = 2'h0;
	logic               fl_clk_range;
	logic               debug_mode;
	logic               prot;
	logic               e;
	logic               seen_pr = 1'h0;
	logic [31:0]        st;
	logic [31:0]        rdv;
	int                 fl_reqs = 0;
	int                 n0;
	int                 errors = 0;
	int                 compares = 0;
	fpmb_link_if fpmb_link_if_i (.ref_clk(ref_clk), .rst_n(rst_n));
	fpmb_host fpmb_host_i (.lnk(fpmb_link_if_i), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	fpmb_device fpmb_device_i (.lnk(fpmb_link_if_i), .fl_req(fl_req),
		.fl_op(fl_op), .fl_addr(fl_addr), .fl_wdata(fl_wd), .fl_rdata(fl_rdata),
		.fl_done(fl_done), .fl_ctrl0(fl_ctrl0), .fl_clk_range(fl_clk_range),
		.gpio_out(4'h0), .gpio_oe(4'h0), .gpio_in(), .jtag_tck(),
		.jtag_tms(tms), .jtag_tdi(), .jtag_tdo(1'h0), .debug_mode(debug_mode));
	fpmb_properties fpmb_properties_i (.ref_clk(ref_clk), .rst_n(rst_n),
		.space(fpmb_link_if_i.space), .op(fpmb_link_if_i.op),
		.addr(fpmb_link_if_i.addr), .ack(fpmb_link_if_i.ack),
		.err(fpmb_link_if_i.err),
		.debug_mode_pin_n(fpmb_link_if_i.debug_mode_pin_n),
		.sleep_state(fpmb_link_if_i.sleep_state),
		.jtag_en(fpmb_link_if_i.jtag_en), .tck_fast(fpmb_link_if_i.tck_fast),
		.jtag_cmd_valid(fpmb_link_if_i.jtag_cmd_valid),
		.jtag_cmd(fpmb_link_if_i.jtag_cmd),
		.power_restore(fpmb_link_if_i.power_restore));
	// ----------------------------------------
	// flash array stand-in, answers two cycles late
	// ----------------------------------------
	always @(posedge ref_clk) begin
		fl_done <= 1'h0;
		if (fpmb_link_if_i.power_restore === 1'h1) begin
			seen_pr <= 1'h1;
		end
		if (fl_req === 1'h1) begin
			fl_cnt <= 2'h2;
			last_fa <= fl_addr;
			last_op <= fl_op;
			fl_reqs <= fl_reqs + 1;
		end else if (fl_cnt != 2'h0) begin
			fl_cnt <= fl_cnt - 2'h1;
			fl_done <= (fl_cnt == 2'h1);
			fl_rdata <= (last_fa == 17'h00400) ? {7'h00, prot} :
				{last_fa[16:15], last_fa[5:0]};
		end
	end
	initial begin
		ref_clk = 1'h0;
		forever #5 ref_clk = ~ref_clk;
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input string n, input logic [31:0] x,
		input logic [31:0] s);
		compares++;
		if (s !== x) begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'h1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		rdv = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		chk("pready", 32'h1, {31'h0, pready});
	endtask
	task automatic poll(input logic [31:0] m, input logic [31:0] v);
		int n;
		n = 0;
		do begin
			apb(1'h0, 12'h004, 32'h0);
			st = rdv;
			n++;
		end while ((st & m) !== v && n < 60);
		chk("status", v, st & m);
	endtask
	// the order word packs wdata, address, op and space under the go bit
	task automatic link(input logic sp, input logic [1:0] op,
		input logic [15:0] a, input logic [7:0] d);
		apb(1'h1, 12'h000, {1'h1, 4'h0, sp, op, a, d});
		poll(32'h1, 32'h0);
		e = st[1];
		rd = st[15:8];
	endtask
	task automatic final_report();
		if (errors == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		#400000;
		errors++;
		final_report();
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		prot = 1'h0;
		rst_n = 1'h0;
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'h1;
		apb(1'h0, 12'h008, 32'h0);
		chk("pins", 32'h3, rdv);
		apb(1'h0, 12'h010, 32'h0);
		chk("unmapped", 32'h1, {31'h0, e});
		link(1'h1, 2'h0, 16'h00a0, 8'h00);
		chk("bank rst", 32'h1, {24'h0, rd});
		for (int b = 1; b < 4; b++) begin
			link(1'h1, 2'h1, 16'h00a0, 8'(b));
			link(1'h0, 2'h0, 16'h9000, 8'h00);
			chk("window", {15'h0, 2'(b), 15'h1000}, {15'h0, last_fa});
			chk("win data", {24'h0, 2'(b), 6'h00}, {24'h0, rd});
			link(1'h0, 2'h0, 16'h1234, 8'h00);
			chk("common", 32'h1234, {15'h0, last_fa});
			chk("com data", 32'h34, {24'h0, rd});
		end
		link(1'h1, 2'h1, 16'h00a0, 8'h00);
		link(1'h1, 2'h0, 16'h00a0, 8'h00);
		chk("bank 00", 32'h3, {24'h0, rd});
		link(1'h1, 2'h0, 16'h00a1, 8'h00);
		chk("sfr err", 32'h1, {31'h0, e});
		n0 = fl_reqs;
		link(1'h0, 2'h1, 16'h0100, 8'h55);
		chk("low write", 32'h1, {31'h0, e});
		link(1'h0, 2'h3, 16'h0000, 8'h00);
		chk("mass norm", 32'h1, {31'h0, e});
		chk("no flash", n0, fl_reqs);
		link(1'h0, 2'h2, 16'h0600, 8'h00);
		chk("page op", 32'h2, {30'h0, last_op});
		link(1'h0, 2'h1, 16'h0402, 8'h40);
		link(1'h0, 2'h0, 16'h0402, 8'h00);
		chk("ctl1 lock", 32'h0, {24'h0, rd});
		link(1'h0, 2'h1, 16'h0402, 8'hc0);
		link(1'h0, 2'h0, 16'h0402, 8'h00);
		chk("ctl1", 32'h40, {24'h0, rd});
		chk("clk range", 32'h1, {31'h0, fl_clk_range});
		link(1'h0, 2'h1, 16'h0401, 8'h5a);
		chk("ctl0", 32'h5a, {24'h0, fl_ctrl0});
		apb(1'h1, 12'h00c, 32'h8);
		link(1'h0, 2'h0, 16'h0402, 8'h00);
		chk("wake ctl1", 32'h0, {24'h0, rd});
		chk("wake ctl0", 32'h0, {24'h0, fl_ctrl0});
		// debug entry, protection clear
		apb(1'h1, 12'h008, 32'h2);
		poll(32'h0009_0000, 32'h0008_0000);
		chk("dbg wire", 32'h1, {31'h0, fpmb_link_if_i.jtag_en});
		chk("dbg out", 32'h1, {31'h0, debug_mode});
		link(1'h0, 2'h0, 16'h1234, 8'h00);
		chk("dbg low rd", 32'h1, {31'h0, e});
		link(1'h0, 2'h0, 16'h9000, 8'h00);
		chk("dbg top rd", 32'h0, {31'h0, e});
		link(1'h0, 2'h1, 16'h9000, 8'h11);
		chk("dbg top wr", 32'h1, {31'h0, e});
		link(1'h0, 2'h3, 16'h0000, 8'h00);
		chk("dbg mass", 32'h0, {31'h0, e});
		apb(1'h1, 12'h00c, 32'h7);
		apb(1'h1, 12'h008, 32'h26);
		link(1'h1, 2'h0, 16'h00a0, 8'h00);
		chk("masked rst", 32'h3, {24'h0, rd});
		chk("tms", 32'h1, {31'h0, tms});
		poll(32'h0006_0000, 32'h0);
		apb(1'h1, 12'h00c, 32'h2210);
		poll(32'h0001_0000, 32'h0001_0000);
		apb(1'h1, 12'h00c, 32'h2310);
		poll(32'h0001_0000, 32'h0);
		// protection only taken at a hard reset
		prot = 1'h1;
		link(1'h0, 2'h0, 16'h1234, 8'h00);
		chk("prot late", 32'h1, {31'h0, e});
		apb(1'h1, 12'h008, 32'h0);
		apb(1'h1, 12'h008, 32'h2);
		link(1'h0, 2'h1, 16'h1234, 8'h77);
		chk("prot wr", 32'h0, {31'h0, e});
		chk("prot data", 32'h77, {24'h0, fl_wd});
		link(1'h1, 2'h0, 16'h00a0, 8'h00);
		chk("pin rst", 32'h1, {24'h0, rd});
		// asleep when debug is selected
		apb(1'h1, 12'h008, 32'h7);
		poll(32'h0006_0000, 32'h0002_0000);
		apb(1'h1, 12'h008, 32'h6);
		poll(32'h0006_0000, 32'h0);
		chk("restore", 32'h1, {31'h0, seen_pr});
		apb(1'h1, 12'h008, 32'h3);
		final_report();
	end
endmodule
`default_nettype wire
